// file: src/pnp_regs.sv
// next-page, link-partner next-page, mmd indirect access and digital control registers
`timescale 1ns/100ps
`include "pnp_cfg.svh"
module pnp_regs #(
    parameter int MMD_AW = 16
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // management pins
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    // auto-negotiation engine: local page out
    output logic [15:0]      local_np_word,
    output logic             local_np_ready,
    input  wire logic        local_np_sent,
    // auto-negotiation engine: partner page in
    input  wire logic [15:0] partner_np_in,
    input  wire logic        partner_np_valid,
    // mmd register spaces
    output logic [4:0]       mmd_device_select,
    output logic [MMD_AW-1:0] mmd_addr,
    output logic [15:0]      mmd_wdata,
    output logic             mmd_wr,
    output logic             mmd_rd,
    input  wire logic [15:0] mmd_rdata,
    // power control
    input  wire logic        energy_detect_power_down,
    output logic             pll_off
);
    logic [4:0]  bus_addr;
    logic [15:0] bus_wdata, bus_rdata;
    logic        bus_wr, bus_rd;

    logic [15:0] lnp_reg,  lnp_next;
    logic        tog_reg,  tog_next;
    logic        rdy_reg,  rdy_next;
    logic [15:0] pnp_reg,  pnp_next;
    logic        prx_reg,  prx_next;
    logic        prd_reg,  prd_next;
    logic [15:0] ctl_reg,  ctl_next;
    logic [MMD_AW-1:0] mad_reg [32];
    logic [MMD_AW-1:0] mad_next [32];
    logic        pll_reg,  pll_next;
    logic        mmd_wr_reg, mmd_wr_next, mmd_rd_reg, mmd_rd_next;
    logic [15:0] mwd_reg,  mwd_next;
    pnp_pkg::pnp_mmd_fn_t fn;
    logic [4:0]  dev;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction

    pnp_mdio_slave u_mdio (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .mdc       (mdc),
        .mdio_in   (mdio_in),
        .mdio_out  (mdio_out),
        .mdio_oe   (mdio_oe),
        .reg_addr  (bus_addr),
        .reg_wdata (bus_wdata),
        .reg_wr    (bus_wr),
        .reg_rd    (bus_rd),
        .reg_rdata (bus_rdata)
    );

    assign fn  = pnp_pkg::pnp_mmd_fn_t'(ctl_reg[`PNP_MMD_FUNC_HI:`PNP_MMD_FUNC_LO]);
    assign dev = ctl_reg[`PNP_MMD_DEV_HI:0];
    assign mmd_device_select = dev;
    assign mmd_addr       = mad_reg[dev];
    assign mmd_wdata      = mwd_reg;
    assign mmd_wr         = mmd_wr_reg;
    assign mmd_rd         = mmd_rd_reg;
    assign local_np_word  = {lnp_reg[15:12], tog_reg, lnp_reg[10:0]};
    assign local_np_ready = rdy_reg;
    assign pll_off        = pll_reg & energy_detect_power_down;

    // read mux
    always_comb begin
        bus_rdata = 16'h0000;
        if (hit(bus_addr, `PNP_OFF_LOCAL_NP)) begin
            bus_rdata = {lnp_reg[15], 1'b0, lnp_reg[13:12], tog_reg, lnp_reg[10:0]};
        end else if (hit(bus_addr, `PNP_OFF_PARTNER_NP)) begin
            bus_rdata = pnp_reg;
        end else if (hit(bus_addr, `PNP_OFF_EXPANSION)) begin
            // value captured at the read strobe, before the clear lands
            bus_rdata[`PNP_EXP_PAGE_BIT] = prd_reg;
        end else if (hit(bus_addr, `PNP_OFF_MMD_CTRL)) begin
            bus_rdata = ctl_reg;
        end else if (hit(bus_addr, `PNP_OFF_MMD_WINDOW)) begin
            if (fn == pnp_pkg::PNP_FN_ADDR) begin
                bus_rdata = 16'(mad_reg[dev]);
            end else begin
                bus_rdata = mmd_rdata;
            end
        end else if (hit(bus_addr, `PNP_OFF_DIG_CTRL)) begin
            bus_rdata[`PNP_DIG_PLL_BIT] = pll_reg;
        end
    end

    always_comb begin
        lnp_next    = lnp_reg;
        tog_next    = tog_reg;
        rdy_next    = rdy_reg;
        pnp_next    = pnp_reg;
        prx_next    = prx_reg;
        prd_next    = prd_reg;
        ctl_next    = ctl_reg;
        mad_next    = mad_reg;
        pll_next    = pll_reg;
        mmd_wr_next = 1'b0;
        mmd_rd_next = 1'b0;
        mwd_next    = mwd_reg;
        if (local_np_sent) begin
            rdy_next = 1'b0;
        end
        if (bus_wr && hit(bus_addr, `PNP_OFF_LOCAL_NP)) begin
            lnp_next = bus_wdata & `PNP_LOCAL_NP_WMASK;
            rdy_next = 1'b1;
            tog_next = ~tog_reg;
        end
        if (bus_wr && hit(bus_addr, `PNP_OFF_MMD_CTRL)) begin
            ctl_next = bus_wdata;
        end
        if (bus_wr && hit(bus_addr, `PNP_OFF_DIG_CTRL)) begin
            pll_next = bus_wdata[`PNP_DIG_PLL_BIT];
        end
        if (bus_rd && hit(bus_addr, `PNP_OFF_EXPANSION)) begin
            prd_next = prx_reg;
            prx_next = 1'b0;
        end
        if (partner_np_valid) begin
            pnp_next = partner_np_in;
            prx_next = 1'b1;
        end
        if (hit(bus_addr, `PNP_OFF_MMD_WINDOW) && (bus_wr || bus_rd)) begin
            if (fn == pnp_pkg::PNP_FN_ADDR) begin
                if (bus_wr) begin
                    mad_next[dev] = bus_wdata[MMD_AW-1:0];
                end
            end else begin
                mmd_wr_next = bus_wr;
                mmd_rd_next = bus_rd;
                mwd_next    = bus_wdata;
            end
        end
        // advance only after the strobe has gone out with the old address
        if ((mmd_rd_reg && fn == pnp_pkg::PNP_FN_INC_RW) ||
            (mmd_wr_reg && (fn == pnp_pkg::PNP_FN_INC_RW || fn == pnp_pkg::PNP_FN_INC_WR))) begin
            mad_next[dev] = mad_reg[dev] + MMD_AW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lnp_reg    <= `PNP_LOCAL_NP_RST;
            tog_reg    <= 1'b0;
            rdy_reg    <= 1'b0;
            pnp_reg    <= 16'h0000;
            prx_reg    <= 1'b0;
            prd_reg    <= 1'b0;
            ctl_reg    <= 16'h0000;
            mad_reg    <= '{default: '0};
            pll_reg    <= 1'b0;
            mmd_wr_reg <= 1'b0;
            mmd_rd_reg <= 1'b0;
            mwd_reg    <= 16'h0000;
        end else begin
            lnp_reg    <= lnp_next;
            tog_reg    <= tog_next;
            rdy_reg    <= rdy_next;
            pnp_reg    <= pnp_next;
            prx_reg    <= prx_next;
            prd_reg    <= prd_next;
            ctl_reg    <= ctl_next;
            mad_reg    <= mad_next;
            pll_reg    <= pll_next;
            mmd_wr_reg <= mmd_wr_next;
            mmd_rd_reg <= mmd_rd_next;
            mwd_reg    <= mwd_next;
        end
    end
endmodule

// file: pkg/pnp_cfg.svh
// register offsets, field positions, reset values and the mdio phy address for the next-page / mmd register group
`ifndef PNP_CFG_SVH
`define PNP_CFG_SVH
`define PNP_OFF_LOCAL_NP    5'h07
`define PNP_OFF_PARTNER_NP  5'h08
`define PNP_OFF_EXPANSION   5'h06
`define PNP_OFF_MMD_CTRL    5'h0d
`define PNP_OFF_MMD_WINDOW  5'h0e
`define PNP_OFF_DIG_CTRL    5'h10
`define PNP_NP_MORE_BIT     15
`define PNP_NP_ACK_BIT      14
`define PNP_NP_MSGPAGE_BIT  13
`define PNP_NP_COMPLY_BIT   12
`define PNP_NP_TOGGLE_BIT   11
`define PNP_LOCAL_NP_RST    16'h2001
`define PNP_LOCAL_NP_WMASK  16'hb7ff
`define PNP_EXP_PAGE_BIT    1
`define PNP_DIG_PLL_BIT     4
`define PNP_MMD_FUNC_HI     15
`define PNP_MMD_FUNC_LO     14
`define PNP_MMD_DEV_HI      4
`define PNP_MDIO_PHYAD      5'h01
`endif

// file: pkg/pnp_pkg.sv
// types shared by the next-page / mmd register group
package pnp_pkg;
    typedef enum logic [1:0] {
        PNP_FN_ADDR    = 2'b00,
        PNP_FN_DATA    = 2'b01,
        PNP_FN_INC_RW  = 2'b10,
        PNP_FN_INC_WR  = 2'b11
    } pnp_mmd_fn_t;
    typedef enum logic [2:0] {
        PNP_ST_IDLE    = 3'b000,
        PNP_ST_HDR     = 3'b001,
        PNP_ST_TA      = 3'b010,
        PNP_ST_RDATA   = 3'b011,
        PNP_ST_WDATA   = 3'b100
    } pnp_mdio_st_t;
endpackage

// file: src/pnp_mdio_slave.sv
// mdio serial slave: decodes clause-22 frames into register read and write strobes
`timescale 1ns/100ps
`include "pnp_cfg.svh"
module pnp_mdio_slave (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // management pins
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    // register side
    output logic [4:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    logic [2:0]  mdc_sync_reg,  mdc_sync_next;
    logic [1:0]  dio_sync_reg,  dio_sync_next;
    pnp_pkg::pnp_mdio_st_t st_reg, st_next;
    logic [5:0]  cnt_reg,  cnt_next;
    logic [13:0] hdr_reg,  hdr_next;
    logic [15:0] sh_reg,   sh_next;
    logic [4:0]  addr_reg, addr_next;
    logic        wr_reg, wr_next, rd_reg, rd_next, out_reg, out_next, oe_reg, oe_next;
    logic        rise, fall;

    assign rise      = mdc_sync_reg[1] & ~mdc_sync_reg[2];
    assign fall      = ~mdc_sync_reg[1] & mdc_sync_reg[2];
    assign reg_addr  = addr_reg;
    assign reg_wdata = sh_reg;
    assign reg_wr    = wr_reg;
    assign reg_rd    = rd_reg;
    assign mdio_out  = out_reg;
    assign mdio_oe   = oe_reg;

    always_comb begin
        mdc_sync_next = {mdc_sync_reg[1:0], mdc};
        dio_sync_next = {dio_sync_reg[0], mdio_in};
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        hdr_next  = hdr_reg;
        sh_next   = sh_reg;
        addr_next = addr_reg;
        wr_next   = 1'b0;
        rd_next   = 1'b0;
        out_next  = out_reg;
        oe_next   = oe_reg;
        unique case (st_reg)
            pnp_pkg::PNP_ST_IDLE: begin
                oe_next = 1'b0;
                // wait for the 01 start pattern after preamble ones
                if (rise) begin
                    hdr_next = {hdr_reg[12:0], dio_sync_reg[1]};
                    if (hdr_reg[0] == 1'b0 && dio_sync_reg[1] == 1'b1 && hdr_reg[1] == 1'b1) begin
                        st_next  = pnp_pkg::PNP_ST_HDR;
                        cnt_next = 6'h0c;
                        hdr_next = 14'h0000;
                    end
                end
            end
            pnp_pkg::PNP_ST_HDR: begin
                // op(2) phyad(5) regad(5)
                if (rise) begin
                    hdr_next = {hdr_reg[12:0], dio_sync_reg[1]};
                    cnt_next = cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        addr_next = hdr_next[4:0];
                        if (hdr_next[9:5] != `PNP_MDIO_PHYAD) begin
                            st_next = pnp_pkg::PNP_ST_IDLE;
                        end else begin
                            st_next  = pnp_pkg::PNP_ST_TA;
                            cnt_next = 6'h02;
                            if (hdr_next[11:10] == 2'b10) begin
                                rd_next = 1'b1;
                            end
                        end
                    end
                end
            end
            pnp_pkg::PNP_ST_TA: begin
                if (hdr_reg[11:10] == 2'b10) begin
                    if (fall) begin
                        cnt_next = cnt_reg - 6'h01;
                        if (cnt_reg == 6'h02) begin
                            sh_next = reg_rdata;
                        end else begin
                            oe_next  = 1'b1;
                            out_next = 1'b0;
                            st_next  = pnp_pkg::PNP_ST_RDATA;
                            cnt_next = 6'h10;
                        end
                    end
                end else if (rise) begin
                    cnt_next = cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        st_next  = pnp_pkg::PNP_ST_WDATA;
                        cnt_next = 6'h10;
                    end
                end
            end
            pnp_pkg::PNP_ST_RDATA: begin
                if (fall) begin
                    if (cnt_reg == 6'h00) begin
                        oe_next  = 1'b0;
                        // stale header bits must not fake a start pattern
                        hdr_next = 14'h0000;
                        st_next = pnp_pkg::PNP_ST_IDLE;
                    end else begin
                        out_next = sh_reg[15];
                        sh_next  = {sh_reg[14:0], 1'b0};
                        cnt_next = cnt_reg - 6'h01;
                    end
                end
            end
            pnp_pkg::PNP_ST_WDATA: begin
                if (rise) begin
                    sh_next  = {sh_reg[14:0], dio_sync_reg[1]};
                    cnt_next = cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        // only a genuine write opcode commits
                        wr_next  = (hdr_reg[11:10] == 2'b01);
                        hdr_next = 14'h0000;
                        st_next  = pnp_pkg::PNP_ST_IDLE;
                    end
                end
            end
            default: st_next = pnp_pkg::PNP_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mdc_sync_reg <= 3'h0;
            dio_sync_reg <= 2'h0;
            st_reg       <= pnp_pkg::PNP_ST_IDLE;
            cnt_reg      <= 6'h00;
            hdr_reg      <= 14'h0000;
            sh_reg       <= 16'h0000;
            addr_reg     <= 5'h00;
            wr_reg       <= 1'b0;
            rd_reg       <= 1'b0;
            out_reg      <= 1'b0;
            oe_reg       <= 1'b0;
        end else begin
            mdc_sync_reg <= mdc_sync_next;
            dio_sync_reg <= dio_sync_next;
            st_reg       <= st_next;
            cnt_reg      <= cnt_next;
            hdr_reg      <= hdr_next;
            sh_reg       <= sh_next;
            addr_reg     <= addr_next;
            wr_reg       <= wr_next;
            rd_reg       <= rd_next;
            out_reg      <= out_next;
            oe_reg       <= oe_next;
        end
    end
endmodule

// file: tb/pnp_regs_chk.sv
// port assertions for the next-page / mmd register group
`timescale 1ns/100ps
module pnp_regs_chk #(
    parameter int MMD_AW = 16
) (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    // observed ports
    input wire logic              mdio_out,
    input wire logic              mdio_oe,
    input wire logic [15:0]       local_np_word,
    input wire logic              local_np_ready,
    input wire logic              local_np_sent,
    input wire logic [MMD_AW-1:0] mmd_addr,
    input wire logic              mmd_wr,
    input wire logic              mmd_rd,
    input wire logic              energy_detect_power_down,
    input wire logic              pll_off
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_access;
        mmd_wr || mmd_rd;
    endsequence
    sequence s_answer;
        ##[1:200] (mdio_oe && !mdio_out);
    endsequence
    AST_PLL_GATE: assert property (pll_off |-> energy_detect_power_down)
        else $error("pll off outside power-down");
    AST_WR_PULSE: assert property (mmd_wr |=> !mmd_wr)
        else $error("mmd write strobe longer than one cycle");
    AST_RD_PULSE: assert property (mmd_rd |=> !mmd_rd)
        else $error("mmd read strobe longer than one cycle");
    AST_ADDR_STEP: assert property (s_access |=> (mmd_addr == $past(mmd_addr)) ||
        (mmd_addr == $past(mmd_addr) + 1'b1)) else $error("mmd address moved by more than one");
    AST_RD_ANSWER: assert property (mmd_rd |-> s_answer)
        else $error("read strobe without a driven answer");
    AST_WR_QUIET: assert property (mmd_wr |-> !mdio_oe)
        else $error("mmd write during a read answer");
    AST_TOGGLE_NEW: assert property ($changed(local_np_word[11]) |-> local_np_ready)
        else $error("toggle moved without a new page");
    AST_READY_HOLD: assert property (local_np_ready && !local_np_sent |=> local_np_ready)
        else $error("page ready dropped without send");
endmodule
bind pnp_regs pnp_regs_chk #(.MMD_AW(MMD_AW)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .local_np_word(local_np_word), .local_np_ready(local_np_ready),
    .local_np_sent(local_np_sent), .mmd_addr(mmd_addr), .mmd_wr(mmd_wr), .mmd_rd(mmd_rd),
    .energy_detect_power_down(energy_detect_power_down), .pll_off(pll_off));

// file: tb/pnp_mdio_master.sv
// station management model: clause-22 frames over mdc and mdio
`timescale 1ns/100ps
`include "pnp_cfg.svh"
module pnp_mdio_master #(
    parameter int HALF = 8
) (
    // clock
    input  wire logic ref_clk,
    // management pins
    output logic      mdc,
    output logic      mdo,
    output logic      mdo_oe,
    input  wire logic mdio_line
);
    initial begin
        mdc = 1'b0;
        mdo = 1'b1;
        mdo_oe = 1'b0;
    end
    // mdc only runs inside a frame; line released from the turnaround on reads
    task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rdat, output logic ta_ok);
        logic [63:0] f;
        f = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, `PNP_MDIO_PHYAD, ra, 2'b10, wd};
        rdat = 16'h0000;
        ta_ok = 1'b1;
        for (int i = 63; i >= 0; i--) begin
            @(posedge ref_clk);
            mdc <= 1'b0;
            mdo <= f[i];
            mdo_oe <= !(rd && i < 18);
            repeat (HALF) @(posedge ref_clk);
            mdc <= 1'b1;
            repeat (HALF) @(posedge ref_clk);
            if (rd && i == 16) ta_ok = (mdio_line === 1'b0);
            if (rd && i < 16) rdat[i] = mdio_line;
        end
        @(posedge ref_clk);
        mdc <= 1'b0;
        mdo_oe <= 1'b0;
        repeat (2*HALF) @(posedge ref_clk);
    endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the next-page / mmd register group
`timescale 1ns/100ps
`include "pnp_cfg.svh"
module tb_top;
    logic        ref_clk, sys_rst, mdc, mdo, mdo_oe, mdio_line, mdio_out, mdio_oe, ta_ok;
    logic [15:0] local_np_word, partner_np_in, mmd_wdata, mmd_rdata, rdat, mmd_addr, wd_last, ad_last;
    logic        local_np_ready, local_np_sent, partner_np_valid, mmd_wr, mmd_rd, pll_off;
    logic        energy_detect_power_down;
    logic [4:0]  mmd_device_select;
    int          err_total, compares, rd_seen;
    assign mdio_line = mdio_oe ? mdio_out : (mdo_oe ? mdo : 1'b1);
    pnp_regs #(.MMD_AW(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .local_np_word(local_np_word), .local_np_ready(local_np_ready),
        .local_np_sent(local_np_sent), .partner_np_in(partner_np_in), .partner_np_valid(partner_np_valid),
        .mmd_device_select(mmd_device_select), .mmd_addr(mmd_addr), .mmd_wdata(mmd_wdata), .mmd_wr(mmd_wr),
        .mmd_rd(mmd_rd), .mmd_rdata(mmd_rdata), .energy_detect_power_down(energy_detect_power_down),
        .pll_off(pll_off));
    pnp_mdio_master mdm (.ref_clk(ref_clk), .mdc(mdc), .mdo(mdo), .mdo_oe(mdo_oe), .mdio_line(mdio_line));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (mmd_wr === 1'b1) wd_last <= mmd_wdata;
        if (mmd_rd === 1'b1) rd_seen++;
        if (mmd_wr === 1'b1 || mmd_rd === 1'b1) ad_last <= mmd_addr;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        mdm.xfer(1'b1, a, 16'h0000, d, ta_ok);
        chk({15'h0000, ta_ok}, 16'h0001, "turnaround");
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mdm.xfer(1'b0, a, d, rdat, ta_ok);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask
    task automatic t_reset();
        chk(local_np_word, `PNP_LOCAL_NP_RST, "page out reset");
        rchk(`PNP_OFF_LOCAL_NP, `PNP_LOCAL_NP_RST, "local reset");
        rchk(`PNP_OFF_PARTNER_NP, 16'h0000, "partner reset");
        rchk(`PNP_OFF_MMD_CTRL, 16'h0000, "control reset");
        rchk(`PNP_OFF_MMD_WINDOW, 16'h0000, "window reset");
        rchk(`PNP_OFF_DIG_CTRL, 16'h0000, "digital reset");
        rchk(5'h1f, 16'h0000, "unmapped");
    endtask
    task automatic t_local();
        wr(`PNP_OFF_LOCAL_NP, 16'hffff);
        rchk(`PNP_OFF_LOCAL_NP, 16'hbfff, "local all ones");
        chk(local_np_word, 16'hbfff, "page out");
        chk({15'h0000, local_np_ready}, 16'h0001, "ready set");
        @(posedge ref_clk) local_np_sent <= 1'b1;
        @(posedge ref_clk) local_np_sent <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({15'h0000, local_np_ready}, 16'h0000, "ready cleared");
        wr(`PNP_OFF_LOCAL_NP, 16'h0000);
        rchk(`PNP_OFF_LOCAL_NP, 16'h0000, "local zero");
    endtask
    task automatic t_partner();
        logic [15:0] pg [2] = '{16'hd9a5, 16'h265a};
        logic [15:0] d;
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk) partner_np_in <= pg[k];
            partner_np_valid <= 1'b1;
            @(posedge ref_clk) partner_np_valid <= 1'b0;
            rd(`PNP_OFF_EXPANSION, d);
            chk({15'h0000, d[1]}, 16'h0001, "page flag set");
            rd(`PNP_OFF_EXPANSION, d);
            chk({15'h0000, d[1]}, 16'h0000, "page flag clear");
            wr(`PNP_OFF_PARTNER_NP, ~pg[k]);
            rchk(`PNP_OFF_PARTNER_NP, pg[k], "partner page");
        end
    endtask
    task automatic t_mmd();
        logic [15:0] ea [3] = '{16'h0040, 16'h0041, 16'h0042};
        logic [15:0] eb [3] = '{16'h0040, 16'h0042, 16'h0043};
        logic [15:0] pa [3] = '{16'h0040, 16'h0040, 16'h0042};
        int n;
        wr(`PNP_OFF_MMD_CTRL, 16'h0003);
        wr(`PNP_OFF_MMD_WINDOW, 16'h0040);
        chk(mmd_addr, 16'h0040, "address set");
        chk({11'h000, mmd_device_select}, 16'h0003, "device select");
        mmd_rdata <= 16'h5a3c;
        for (int k = 0; k < 3; k++) begin
            n = rd_seen;
            wr(`PNP_OFF_MMD_CTRL, {2'(k + 1), 14'h0003});
            rchk(`PNP_OFF_MMD_CTRL, {2'(k + 1), 14'h0003}, "function");
            rchk(`PNP_OFF_MMD_WINDOW, 16'h5a3c, "mmd data");
            chk(16'(rd_seen - n), 16'h0001, "read strobe");
            chk(ad_last, pa[k], "read address");
            chk(mmd_addr, ea[k], "after read");
            wr(`PNP_OFF_MMD_WINDOW, 16'h1100 + 16'(k));
            chk(wd_last, 16'h1100 + 16'(k), "mmd write");
            chk(ad_last, ea[k], "write address");
            chk(mmd_addr, eb[k], "after write");
        end
        wr(`PNP_OFF_MMD_CTRL, 16'h0003);
        rchk(`PNP_OFF_MMD_WINDOW, 16'h0043, "address read back");
    endtask
    task automatic t_pll();
        @(posedge ref_clk) energy_detect_power_down <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({15'h0000, pll_off}, 16'h0000, "pll kept on");
        wr(`PNP_OFF_DIG_CTRL, 16'h0010);
        rchk(`PNP_OFF_DIG_CTRL, 16'h0010, "digital control");
        chk({15'h0000, pll_off}, 16'h0001, "pll off");
        @(posedge ref_clk) energy_detect_power_down <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({15'h0000, pll_off}, 16'h0000, "pll on awake");
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        $display("MISMATCH %0t run did not finish", $time);
        final_report();
    end
    initial begin
        sys_rst = 1'b1;
        local_np_sent = 1'b0;
        partner_np_in = 16'h0000;
        partner_np_valid = 1'b0;
        mmd_rdata = 16'h0000;
        energy_detect_power_down = 1'b0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_local();
        t_partner();
        t_mmd();
        t_pll();
        final_report();
    end
endmodule
